// ==== core/sros_top.sv ====
// result output stage: SPI and I2C result fetch, measurement requests,
// data-ready flag, two density streams with clipping, two threshold alarms
// assumes a front end that measures on measure_request and pulses
// result_valid with fresh results, and nonvolatile words on plain inputs
//
// Overview of operation
// - data changes falling edge, phase bit swaps
// - either SPI clock idle level works
// - packet: cap high, cap low, temperature, pad
// - fetch may end after two or three
// - request in sleep starts one measurement
// - I2C address with write acked, measures
// - write with extra data bytes also requests
// - SPI read of any length requests measurement
// - ready rises on results, holds until fetch
// - ready driver push-pull or open-drain
// - density streams replace ready, low alarm
// - density rate is clock over eight
// - density reloads each completed conversion
// - density values clipped to upper, lower
// - alarms update only on completed conversion
// - both-streams mode keeps only high alarm
// - high alarm on at on, off lower
// - low alarm on at on, off higher
// - each alarm push-pull or open-drain
// - polarity bit zero high, one low
// - inverted polarity swaps alarm type
// - packet latched at fetch start, held
`timescale 1ns/1ns
module sros_top
    import sros_pkg::*;
#(
    parameter int VAL_W = 14
) (
    // system
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // configuration words from the nonvolatile store
    input  wire logic [2:0]       output_select,
    input  wire logic             sleep_mode,
    input  wire logic             spi_phase_swap,
    input  wire logic             ready_open_drain,
    input  wire logic [6:0]       slave_address,
    input  wire logic             address_lock,
    input  wire logic [VAL_W-1:0] density_clip_upper,
    input  wire logic [VAL_W-1:0] density_clip_lower,
    input  wire logic [VAL_W-1:0] upper_trip_on_level,
    input  wire logic [VAL_W-1:0] upper_trip_off_level,
    input  wire logic [VAL_W-1:0] lower_trip_on_level,
    input  wire logic [VAL_W-1:0] lower_trip_off_level,
    input  wire logic             upper_alarm_open_drain,
    input  wire logic             upper_alarm_polarity,
    input  wire logic             lower_alarm_open_drain,
    input  wire logic             lower_alarm_polarity,
    // measurement front end
    output logic                  measure_request,
    input  wire logic             result_valid,
    input  wire logic [VAL_W-1:0] result_cap,
    input  wire logic [VAL_W-1:0] result_temp,
    // SPI pins
    input  wire logic             spi_sclk,
    input  wire logic             spi_select_n,
    output logic                  spi_miso_o,
    output logic                  spi_miso_oe,
    // I2C pins
    input  wire logic             i2c_scl_i,
    input  wire logic             i2c_sda_i,
    output logic                  i2c_sda_o,
    output logic                  i2c_sda_oe,
    // ready / capacitance density pin
    output logic                  ready_pin_o,
    output logic                  ready_pin_oe,
    // high alarm pin
    output logic                  upper_alarm_o,
    output logic                  upper_alarm_oe,
    // low alarm / temperature density pin
    output logic                  lower_alarm_o,
    output logic                  lower_alarm_oe
);

    // ************************************************************
    // result packet and mode decode
    // ************************************************************
    logic [SROS_PKT_BITS-1:0] packet;        // newest results, packed
    logic [SROS_PKT_BITS-1:0] spi_shadow;    // frozen copy for the SPI side
    logic [SROS_PKT_BITS-1:0] i2c_snap;      // frozen copy for the I2C side
    logic                     spi_mode;      // SPI selected
    logic                     dens_c_on;     // capacitance stream selected
    logic                     dens_t_on;     // temperature stream selected
    logic                     fetch_done;    // a fetch finished this cycle
    logic                     i2c_req;       // I2C write address acked
    logic                     spi_end;       // SPI select just rose

    assign spi_mode  = (output_select == SROS_SEL_SPI);
    assign dens_t_on = (output_select == SROS_SEL_DENS_B);
    assign dens_c_on = (output_select == SROS_SEL_DENS_C) || dens_t_on;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            packet <= '0;
        end else if (result_valid) begin
            packet <= {SROS_STATUS, result_cap, result_temp, SROS_PAD_BITS};
        end
    end

    // ************************************************************
    // SPI select synchroniser into the system domain
    // ************************************************************
    logic ss_s1;   // first stage, read only by the second
    logic ss_s2;   // synchronised select
    logic ss_s3;   // delayed copy for edge detect

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ss_s1 <= 1'b1;
            ss_s2 <= 1'b1;
            ss_s3 <= 1'b1;
        end else begin
            ss_s1 <= spi_select_n;
            ss_s2 <= ss_s1;
            ss_s3 <= ss_s2;
        end
    end
    assign spi_end = spi_mode && ss_s2 && !ss_s3;

    // shadow reloads only while SPI idle
    // the word is held still for the whole frame, so the link side may
    // read it without a handshake; the master's select-to-clock gap
    // covers the two-stage delay
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            spi_shadow <= '0;
        end else if (ss_s2) begin
            spi_shadow <= packet;
        end
    end

    // ************************************************************
    // SPI link domain, clocked by the master's serial clock
    // ************************************************************
    logic       link_clk;    // sample edge is this clock's rising edge
    logic       seen_sample; // a sample edge occurred in this frame
    logic [5:0] bit_index;   // bits already handed out

    // phase bit swaps the sampling edge
    assign link_clk = spi_sclk ^ spi_phase_swap;

    // select high clears the frame; the clock may stop outside frames
    always_ff @(posedge link_clk or posedge spi_select_n) begin
        if (spi_select_n) begin
            seen_sample <= 1'b0;
        end else begin
            seen_sample <= 1'b1;
        end
    end

    // change edge before first sample ignored
    // early select rise simply ends frame
    always_ff @(negedge link_clk or posedge spi_select_n) begin
        if (spi_select_n) begin
            bit_index <= '0;
        end else if (seen_sample && bit_index != 6'(SROS_PKT_BITS)) begin
            bit_index <= bit_index + 6'h01;
        end
    end

    // first bit stands from select fall, later ones after change edges
    assign spi_miso_o  = (bit_index < 6'(SROS_PKT_BITS)) ?
                         spi_shadow[5'(SROS_PKT_BITS - 1) - bit_index[4:0]] : 1'b0;
    assign spi_miso_oe = spi_mode && !spi_select_n;

    // ************************************************************
    // I2C pin synchronisers and bus conditions
    // ************************************************************
    logic [2:0] scl_q;   // [0] first stage only feeds [1]
    logic [2:0] sda_q;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= {scl_q[1:0], i2c_scl_i};
            sda_q <= {sda_q[1:0], i2c_sda_i};
        end
    end
    assign scl_rise  = scl_q[1] && !scl_q[2];
    assign scl_fall  = !scl_q[1] && scl_q[2];
    assign bus_start = scl_q[1] && scl_q[2] && !sda_q[1] && sda_q[2];
    assign bus_stop  = scl_q[1] && scl_q[2] && sda_q[1] && !sda_q[2];

    // ************************************************************
    // I2C slave: address, write ack, packet read
    // ************************************************************
    sros_i2c_e  i2c_state;
    logic [3:0] i2c_bits;     // bits moved in the current byte
    logic [7:0] i2c_shift;    // received byte
    logic [1:0] i2c_byte;     // read byte index
    logic       i2c_drive_lo; // pull SDA low
    logic       addr_hit;

    assign addr_hit = !address_lock || (i2c_shift[7:1] == slave_address);

    // one process keeps the frame; SDA only changes while SCL is low
    always_ff @(posedge clk_sys) begin
        i2c_req    <= 1'b0;
        fetch_done <= spi_end;
        if (sys_rst || spi_mode || bus_stop) begin
            i2c_state    <= SROS_I2C_IDLE;
            i2c_drive_lo <= 1'b0;
            i2c_bits     <= '0;
            i2c_byte     <= '0;
            // SPI mode parks the I2C frame, but a select rise still counts as a fetch
            fetch_done   <= spi_end && !sys_rst;
            i2c_snap     <= '0;
            if (bus_stop && !sys_rst && !spi_mode && i2c_state == SROS_I2C_RACK) begin
                fetch_done <= 1'b1;
            end
        end else if (bus_start) begin
            i2c_state    <= SROS_I2C_ADDR;
            i2c_drive_lo <= 1'b0;
            i2c_bits     <= '0;
        end else if (scl_rise) begin
            i2c_bits  <= i2c_bits + 4'h1;
            i2c_shift <= {i2c_shift[6:0], sda_q[1]};
            // master not-acknowledge ends the read
            if (i2c_state == SROS_I2C_RACK && sda_q[1]) begin
                i2c_state  <= SROS_I2C_IDLE;
                fetch_done <= 1'b1;
            end
        end else if (scl_fall) begin
            case (i2c_state)
                SROS_I2C_ADDR: begin
                    if (i2c_bits == 4'h8) begin
                        i2c_state    <= addr_hit ? SROS_I2C_AACK : SROS_I2C_IDLE;
                        i2c_drive_lo <= addr_hit;
                    end
                end
                SROS_I2C_AACK: begin
                    i2c_bits <= '0;
                    // the ack clock shifted one more bit in, so r/w now sits at [1]
                    if (i2c_shift[1]) begin
                        i2c_snap     <= packet;
                        i2c_byte     <= '0;
                        i2c_state    <= SROS_I2C_RDATA;
                        i2c_drive_lo <= !packet[SROS_PKT_BITS-1];
                    end else begin
                        i2c_req      <= 1'b1;
                        i2c_state    <= SROS_I2C_WDATA;
                        i2c_drive_lo <= 1'b0;
                    end
                end
                SROS_I2C_WDATA: begin
                    if (i2c_bits == 4'h8) begin
                        i2c_state    <= SROS_I2C_WACK;
                        i2c_drive_lo <= 1'b1;
                    end
                end
                SROS_I2C_WACK: begin
                    i2c_bits     <= '0;
                    i2c_state    <= SROS_I2C_WDATA;
                    i2c_drive_lo <= 1'b0;
                end
                SROS_I2C_RDATA: begin
                    if (i2c_bits == 4'h8) begin
                        i2c_state    <= SROS_I2C_RACK;
                        i2c_drive_lo <= 1'b0;
                    end else begin
                        i2c_drive_lo <= !i2c_snap[5'(SROS_PKT_BITS - 1)
                                        - {i2c_byte, i2c_bits[2:0]}];
                    end
                end
                SROS_I2C_RACK: begin
                    i2c_bits     <= '0;
                    i2c_byte     <= i2c_byte + 2'h1;
                    i2c_state    <= SROS_I2C_RDATA;
                    i2c_drive_lo <= !i2c_snap[5'(SROS_PKT_BITS - 1)
                                    - {i2c_byte + 2'h1, 3'h0}];
                end
                default: begin
                    i2c_drive_lo <= 1'b0;
                end
            endcase
        end
    end
    assign i2c_sda_o  = 1'b0;
    assign i2c_sda_oe = i2c_drive_lo;

    // ************************************************************
    // measurement request towards the front end
    // ************************************************************
    // requests honoured only in sleep
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            measure_request <= 1'b0;
        end else begin
            measure_request <= sleep_mode && (i2c_req || spi_end);
        end
    end

    // ************************************************************
    // data-ready flag
    // ************************************************************
    logic data_ready;   // new results not yet fetched

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            data_ready <= 1'b0;
        end else if (result_valid) begin
            data_ready <= 1'b1;
        end else if (fetch_done) begin
            data_ready <= 1'b0;
        end
    end

    // ************************************************************
    // density streams, one first-order modulator per channel
    // ************************************************************
    logic [2:0] dens_div;    // oscillator-over-eight tick
    logic       dens_tick;
    logic [1:0] dens_bit;    // [0] capacitance, [1] temperature

    // one density bit per eight clocks
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dens_div <= '0;
        end else begin
            dens_div <= (dens_div == SROS_DENS_LAST) ? 3'h0 : dens_div + 3'h1;
        end
    end
    assign dens_tick = (dens_div == SROS_DENS_LAST);

    // clamp one value between the two limits
    function automatic logic [VAL_W-1:0] clip_value(input logic [VAL_W-1:0] v);
        if (v > density_clip_upper) begin
            clip_value = density_clip_upper;
        end else if (v < density_clip_lower) begin
            clip_value = density_clip_lower;
        end else begin
            clip_value = v;
        end
    endfunction : clip_value

    for (genvar ch = 0; ch < 2; ch++) begin : g_dens
        logic [VAL_W-1:0] level;   // value being emitted
        logic [VAL_W:0]   acc;     // accumulator, carry is the output bit
        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                level <= '0;
            end else if (result_valid) begin
                level <= clip_value(ch == 0 ? result_cap : result_temp);
            end
        end
        // carry out of a 14-bit accumulator gives level/2^14 density
        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                acc <= '0;
            end else if (dens_tick) begin
                acc <= {1'b0, acc[VAL_W-1:0]} + {1'b0, level};
            end
        end
        assign dens_bit[ch] = acc[VAL_W];
    end

    // ************************************************************
    // threshold alarms with hysteresis
    // ************************************************************
    logic upper_active;   // high-type trip state
    logic lower_active;   // low-type trip state
    logic upper_level;    // pin level after polarity
    logic lower_level;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            upper_active <= 1'b0;
            lower_active <= 1'b0;
        end else if (result_valid) begin
            // on at threshold, off at lower
            if (!upper_active && result_cap >= upper_trip_on_level) begin
                upper_active <= 1'b1;
            end else if (upper_active && result_cap <= upper_trip_off_level) begin
                upper_active <= 1'b0;
            end
            // on falling to threshold, off higher
            if (!lower_active && result_cap <= lower_trip_on_level) begin
                lower_active <= 1'b1;
            end else if (lower_active && result_cap >= lower_trip_off_level) begin
                lower_active <= 1'b0;
            end
        end
    end

    // inverted pin acts as opposite type
    assign upper_level = upper_active ^ upper_alarm_polarity;
    assign lower_level = lower_active ^ lower_alarm_polarity;

    // ************************************************************
    // pin drivers
    // ************************************************************
    // ready driver selectable; stream replaces it
    always_comb begin
        if (dens_c_on) begin
            ready_pin_o  = dens_bit[0];
            ready_pin_oe = 1'b1;
        end else begin
            ready_pin_o  = ready_open_drain ? 1'b0 : data_ready;
            ready_pin_oe = ready_open_drain ? !data_ready : 1'b1;
        end
    end

    assign upper_alarm_o  = upper_alarm_open_drain ? 1'b0 : upper_level;
    assign upper_alarm_oe = upper_alarm_open_drain ? !upper_level : 1'b1;

    // both streams leave only high alarm
    always_comb begin
        if (dens_t_on) begin
            lower_alarm_o  = dens_bit[1];
            lower_alarm_oe = 1'b1;
        end else begin
            lower_alarm_o  = lower_alarm_open_drain ? 1'b0 : lower_level;
            lower_alarm_oe = lower_alarm_open_drain ? !lower_level : 1'b1;
        end
    end

endmodule : sros_top

// ==== core/sros_pkg.sv ====
// package for the sensor result output stage
// assumes a single 10 MHz system clock and an SPI clock domain from the master
package sros_pkg;
    // ************************************************************
    // output selection codes (3-bit field)
    // ************************************************************
    localparam logic [2:0] SROS_SEL_I2C    = 3'h1;
    localparam logic [2:0] SROS_SEL_SPI    = 3'h3;
    localparam logic [2:0] SROS_SEL_DENS_C = 3'h4;
    localparam logic [2:0] SROS_SEL_DENS_B = 3'h6;

    // ************************************************************
    // nonvolatile word addresses and reset values
    // ************************************************************
    localparam logic [7:0]  SROS_ADR_CLIP_UPPER = 8'h16;
    localparam logic [7:0]  SROS_ADR_CLIP_LOWER = 8'h17;
    localparam logic [13:0] SROS_CLIP_RESET     = 14'h0000;

    // ************************************************************
    // packet layout and serial framing
    // ************************************************************
    localparam int          SROS_PKT_BITS  = 32;
    localparam int          SROS_BYTE_BITS = 8;
    localparam logic [1:0]  SROS_PAD_BITS  = 2'h0;
    localparam logic [1:0]  SROS_STATUS    = 2'h0;

    // ************************************************************
    // timing: density output rate is the oscillator over eight
    // ************************************************************
    localparam int          SROS_CLK_HZ    = 10_000_000;
    localparam int          SROS_DENS_DIV  = 8;
    localparam logic [2:0]  SROS_DENS_LAST = 3'(SROS_DENS_DIV - 1);

    // ************************************************************
    // serial slave states
    // ************************************************************
    typedef enum logic [6:0] {
        SROS_I2C_IDLE  = 7'h01,
        SROS_I2C_ADDR  = 7'h02,
        SROS_I2C_AACK  = 7'h04,
        SROS_I2C_WDATA = 7'h08,
        SROS_I2C_WACK  = 7'h10,
        SROS_I2C_RDATA = 7'h20,
        SROS_I2C_RACK  = 7'h40
    } sros_i2c_e;
endpackage : sros_pkg

// ==== dv/sros_assertions.sv ====
// checker on the output stage pins
// assumes configuration stays static while results arrive
`timescale 1ns/1ns
module sros_assertions
    import sros_pkg::*;
#(parameter int VAL_W = 14) (
    // watched ports
    input wire logic             clk_sys,
    input wire logic             sys_rst,
    input wire logic [2:0]       output_select,
    input wire logic             sleep_mode,
    input wire logic             ready_open_drain,
    input wire logic [VAL_W-1:0] upper_trip_on_level,
    input wire logic [VAL_W-1:0] upper_trip_off_level,
    input wire logic             upper_alarm_open_drain,
    input wire logic             upper_alarm_polarity,
    input wire logic             measure_request,
    input wire logic             result_valid,
    input wire logic [VAL_W-1:0] result_cap,
    input wire logic             spi_select_n,
    input wire logic             spi_miso_oe,
    input wire logic             ready_pin_o,
    input wire logic             upper_alarm_o
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // pins whose level equals the flag, so the flag is visible
    wire rdy_pp = !output_select[2] && !ready_open_drain;
    wire hi_ok  = !upper_alarm_open_drain && !upper_alarm_polarity
                  && (upper_trip_on_level > upper_trip_off_level);
    ready_rise_a: assert property (result_valid && rdy_pp |=> ready_pin_o)
        else $error("ready not raised");
    ready_od_a: assert property (ready_open_drain |-> !ready_pin_o)
        else $error("open drain pin driven high");
    req_pulse_a: assert property (measure_request |=> !measure_request)
        else $error("request too long");
    req_sleep_a: assert property (measure_request |-> $past(sleep_mode))
        else $error("request while awake");
    miso_drive_a: assert property (
        spi_miso_oe == (output_select == SROS_SEL_SPI && !spi_select_n))
        else $error("miso enable wrong");
    upper_on_a: assert property (result_valid && hi_ok && result_cap >= upper_trip_on_level
        |=> upper_alarm_o) else $error("high alarm not set");
    upper_off_a: assert property (result_valid && hi_ok && result_cap <= upper_trip_off_level
        |=> !upper_alarm_o) else $error("high alarm not cleared");
    alarm_hold_a: assert property ($changed(upper_alarm_o) && $stable(upper_alarm_polarity)
        |-> $past(result_valid)) else $error("alarm moved without result");
endmodule : sros_assertions
bind sros_top sros_assertions #(.VAL_W(VAL_W)) i_chk (.*);

// ==== dv/sros_spi_master.sv ====
// SPI master model that fetches result packets
// assumes spi_miso_oe marks the pin as driven
`timescale 1ns/1ns
module sros_spi_master (
    // link clock and SPI pins
    input  wire logic clk_link,
    output logic      spi_sclk,
    output logic      spi_select_n,
    input  wire logic spi_miso_o,
    input  wire logic spi_miso_oe
);
    logic last_bit = 1'h0; // last driven level
    // a released line shows the inverse, so a stale bit never passes
    wire  miso_line = spi_miso_oe ? spi_miso_o : !last_bit;
    initial spi_sclk = 1'h0;
    initial spi_select_n = 1'h1;
    always @(posedge clk_link) if (spi_miso_oe) last_bit <= spi_miso_o;
    // idle level, length free; clock stands still outside frames
    task automatic fetch(input int nbits, input logic idle, output logic [31:0] bits);
        bits = '0;
        @(posedge clk_link) spi_sclk <= idle;
        @(posedge clk_link) spi_select_n <= 1'h0;
        repeat (170) @(posedge clk_link); // select to clock, 2.55 us
        for (int i = 31; i > 31 - nbits; i--) begin
            spi_sclk <= 1'h0;
            repeat (48) @(posedge clk_link);
            spi_sclk <= 1'h1;
            bits[i] = miso_line;
            repeat (48) @(posedge clk_link);
        end
        spi_sclk <= idle;
        repeat (48) @(posedge clk_link);
        spi_select_n <= 1'h1;
        repeat (140) @(posedge clk_link); // bus free time
    endtask : fetch
endmodule : sros_spi_master

// ==== dv/sros_top_test.sv ====
// self-checking bench for the result output stage
// assumes the SPI master model and the bound checker
`timescale 1ns/1ns
module sros_top_test;
    import sros_pkg::*;
    // ************************************************************
    // pins, counters and the alarm walk table
    // ************************************************************
    logic        clk_sys = 1'h0, clk_link = 1'h0, sys_rst = 1'h1, result_valid = 1'h0;
    logic [2:0]  output_select = SROS_SEL_SPI;
    logic        sleep_mode = 1'h1, ready_open_drain = 1'h0;
    logic [13:0] density_clip_upper = 14'h0, density_clip_lower = 14'h0;
    logic [13:0] upper_trip_on_level = 14'h3000, upper_trip_off_level = 14'h2000;
    logic [13:0] lower_trip_on_level = 14'h0800, lower_trip_off_level = 14'h1000;
    logic        upper_alarm_open_drain = 1'h0, upper_alarm_polarity = 1'h0;
    logic        lower_alarm_open_drain = 1'h0, lower_alarm_polarity = 1'h0;
    logic [13:0] result_cap = 14'h0, result_temp = 14'h0;
    logic        measure_request, spi_sclk, spi_select_n, spi_miso_o, spi_miso_oe;
    logic        ready_pin_o, ready_pin_oe, upper_alarm_o, upper_alarm_oe;
    logic        lower_alarm_o, lower_alarm_oe;
    logic [31:0] pkt;
    int          n_mismatch = 0, checked = 0, n_meas = 0, n_high;
    typedef struct {logic [13:0] cap; logic hi; logic lo;} sros_row_s;
    // hysteresis walk, trip points hit exactly
    sros_row_s rows [7] = '{'{14'h1800, 0, 0}, '{14'h3000, 1, 0}, '{14'h2001, 1, 0},
        '{14'h2000, 0, 0}, '{14'h0800, 0, 1}, '{14'h0FFF, 0, 1}, '{14'h1000, 0, 0}};
    sros_top i_dut (.*, .spi_phase_swap(1'h0), .slave_address(7'h00), .address_lock(1'h0),
                    .i2c_scl_i(1'h1), .i2c_sda_i(1'h1), .i2c_sda_o(), .i2c_sda_oe());
    sros_spi_master i_master (.*);
    always #50 clk_sys = !clk_sys;
    always begin #7 clk_link = 1'h1; #8 clk_link = 1'h0; end
    always @(posedge clk_sys) if (measure_request === 1'h1) n_meas++;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one completed conversion, outputs looked at once settled
    task automatic pulse(input logic [13:0] cap);
        @(posedge clk_sys);
        result_cap <= cap;
        result_temp <= ~cap;
        result_valid <= 1'h1;
        @(posedge clk_sys) result_valid <= 1'h0;
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : pulse
    task automatic summarize;
        $display("mismatches %0d of %0d checks", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'h0;
        @(negedge clk_sys);
        chk("ready", 0, ready_pin_o);
        chk("upper alarm", 0, upper_alarm_o);
        foreach (rows[i]) begin
            pulse(rows[i].cap);
            chk("upper alarm", rows[i].hi, upper_alarm_o);
            chk("lower alarm", rows[i].lo, lower_alarm_o);
            chk("ready", 1, ready_pin_o);
        end
        // short fetch with clock idling high, then a refused request while awake
        i_master.fetch(16, 1'h1, pkt);
        chk("cap bytes", 32'h1000, pkt[31:16]);
        chk("requests", 1, n_meas);
        chk("ready", 0, ready_pin_o);
        @(posedge clk_sys) sleep_mode <= 1'h0;
        i_master.fetch(8, 1'h0, pkt);
        chk("cap high", 32'h10, pkt[31:24]);
        chk("requests", 1, n_meas);
        // full packet while a new result lands in mid-transfer
        @(posedge clk_sys) sleep_mode <= 1'h1;
        fork
            i_master.fetch(32, 1'h0, pkt);
            begin #5000; pulse(14'h0123); end
        join
        chk("packet", {2'h0, 14'h1000, 14'h2FFF, 2'h0}, pkt & 32'hFFFFFFFC);
        chk("requests", 2, n_meas);
        @(posedge clk_sys);
        ready_open_drain <= 1'h1;
        lower_alarm_open_drain <= 1'h1;
        lower_alarm_polarity <= 1'h1;
        pulse(14'h0123);
        chk("ready enable", 0, ready_pin_oe);
        chk("lower enable", 1, lower_alarm_oe);
        @(posedge clk_sys);
        ready_open_drain <= 1'h0;
        lower_alarm_open_drain <= 1'h0;
        upper_alarm_polarity <= 1'h1;
        pulse(14'h3FFF);
        chk("upper alarm", 0, upper_alarm_o);
        pulse(14'h2000);
        chk("upper alarm", 1, upper_alarm_o);
        // limits set before use; half-scale clip, half density on both pins
        @(posedge clk_sys);
        output_select <= SROS_SEL_DENS_B;
        density_clip_upper <= 14'h2000;
        density_clip_lower <= 14'h2000;
        pulse(14'h0123);
        n_high = 0;
        repeat (512) @(negedge clk_sys) n_high += ready_pin_o + lower_alarm_o;
        chk("density", 1, n_high >= 496 && n_high <= 528);
        summarize;
    end
    initial begin
        #1_000_000;
        n_mismatch++;
        summarize;
    end
endmodule : sros_top_test
